// >>> core/operand_address_generator.sv
`timescale 1ns/1ps

// Functional notes
// - Register mode takes the operand from the named register or pair.
// - Working registers: pointer picks an 8-byte slice, instruction picks the register.
// - Indirect register mode uses register or pair contents as the operand address.
// - Any 8-bit register points to a register; any 16-bit pair points to memory.
// - Indirect register mode cannot reach set 1 locations C0H to FFH.
// - Indexed mode cannot reach set 1 locations C0H to FFH either.
// - Short-offset indexed external access uses a signed 8-bit displacement.
// - Indexed register-file address is instruction base plus working-register offset.
// - Indexed memory address is working pair base plus 8- or 16-bit offset.
// - Indexed register file only for plain load; memory loads index their memories.
// - Direct mode 16-bit address loads the program counter for jump and call.
// - Memory loads accept a direct 16-bit address as source or destination.
// - Indirect vector: zero-extended 8-bit pointer into lowest 256 bytes, fetch pair.
// - Indirect vector mode is accepted only on the call instruction.
// - Relative mode adds signed displacement to the already advanced program counter.
// - Relative mode decoded for six branch and relative jump instructions.
// - Immediate mode uses the operand field, byte or word wide.
// - 4-bit working address: top bit picks pointer, pointer top five plus low three.
// - 8-bit address with upper nibble 1100B resolves as 4-bit working address.
module operand_address_generator (
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  input  wire logic               req_valid_i,
  input  wire oag_pkg::decode_req_s req_i,
  input  wire logic [15:0]        pc_next_i,
  input  wire logic               reg_wr_i,
  input  wire logic [7:0]         reg_wr_addr_i,
  input  wire logic [7:0]         reg_wr_data_i,
  output logic [7:0]              rf_addr_o,
  input  wire logic [7:0]         rf_rdata_i,
  input  wire logic [7:0]         rf_rdata_hi_i,
  output logic [15:0]             vec_addr_o,
  input  wire logic [15:0]        vec_rdata_i,
  output logic                    rsp_valid_o,
  output oag_pkg::decode_rsp_s    rsp_o,
  output logic [7:0]              working_pointer_zero_o,
  output logic [7:0]              working_pointer_one_o
);
  import oag_pkg::*;

  logic [7:0]  working_pointer_zero_q;
  logic [7:0]  working_pointer_one_q;
  decode_rsp_s rsp_d;
  decode_rsp_s rsp_q;
  logic        rsp_valid_q;

  // Resolves a 4-bit working address through the selected pointer.
  function automatic logic [7:0] working_addr(input logic [3:0] nib,
                                              input logic [7:0] wp0,
                                              input logic [7:0] wp1);
    logic [7:0] ptr;
    ptr = nib[POINTER_SEL_BIT] ? wp1 : wp0;
    return {ptr[7:SLICE_LOW_BITS], nib[SLICE_LOW_BITS-1:0]};
  endfunction

  // Any 8-bit field with the 1100B prefix is a working-register reference.
  function automatic logic [7:0] resolve_reg(input logic [7:0] field,
                                             input logic [7:0] wp0,
                                             input logic [7:0] wp1);
    logic [7:0] res;
    res = field;
    if (field[7:4] == WORKING_NIBBLE_PREFIX) begin
      res = working_addr(field[3:0], wp0, wp1);
    end
    return res;
  endfunction

  // Register-file pointers from indirect and indexed forms must stay below set 1.
  function automatic logic in_set1_upper(input logic [7:0] a);
    return a >= SET1_PROTECT_BASE;
  endfunction

  wire logic [7:0]  src_reg     = resolve_reg(req_i.reg_field, working_pointer_zero_q,
                                              working_pointer_one_q);
  wire logic [15:0] pair_value  = {rf_rdata_hi_i, rf_rdata_i};
  wire logic [7:0]  idx_sum     = 8'(req_i.operand[7:0] + rf_rdata_i);
  wire logic [15:0] short_disp  = {{8{req_i.operand[7]}}, req_i.operand[7:0]};
  wire logic [15:0] idx_offset  = req_i.short_offset ? short_disp : req_i.operand;
  wire logic [15:0] idx_mem     = 16'(pair_value + idx_offset);
  wire logic [15:0] rel_disp    = {{8{req_i.operand[7]}}, req_i.operand[7:0]};
  wire logic [15:0] rel_target  = 16'(pc_next_i + rel_disp);
  wire logic        is_mem_load = (req_i.opcode == OP_PROGRAM_MEMORY_LOAD) ||
                                  (req_i.opcode == OP_EXTERNAL_DATA_LOAD);
  wire logic        is_branch   = (req_i.opcode == OP_BIT_TEST_BRANCH_FALSE) ||
                                  (req_i.opcode == OP_BIT_TEST_BRANCH_TRUE) ||
                                  (req_i.opcode == OP_DECREMENT_BRANCH_NONZERO) ||
                                  (req_i.opcode == OP_COMPARE_INC_BRANCH_EQUAL) ||
                                  (req_i.opcode == OP_COMPARE_INC_BRANCH_UNEQUAL) ||
                                  (req_i.opcode == OP_RELATIVE_JUMP);
  wire target_e     mem_tgt     = (req_i.opcode == OP_PROGRAM_MEMORY_LOAD) ? TGT_PROGRAM
                                                                            : TGT_EXTERNAL;

  // For indexed forms the working-register file supplies the offset or base pair.
  wire logic [7:0]  idx_reg     = working_addr(req_i.reg_field[3:0], working_pointer_zero_q,
                                               working_pointer_one_q);

  assign rf_addr_o  = (req_i.mode == MODE_INDEXED) ? idx_reg : src_reg;
  assign vec_addr_o = {8'h00, req_i.operand[7:0]};

  always_comb begin
    rsp_d         = '0;
    rsp_d.target  = TGT_NONE;
    case (req_i.mode)
      MODE_REGISTER: begin
        rsp_d.target = TGT_VALUE;
        rsp_d.value  = req_i.pair ? pair_value : {8'h00, rf_rdata_i};
      end
      MODE_INDIRECT_REGISTER: begin
        if (req_i.use_memory_space) begin
          rsp_d.target  = is_mem_load ? mem_tgt : TGT_PROGRAM;
          rsp_d.address = pair_value;
        end else begin
          rsp_d.target  = TGT_REGFILE;
          rsp_d.address = {8'h00, rf_rdata_i};
          rsp_d.illegal = in_set1_upper(rf_rdata_i);
        end
      end
      MODE_INDEXED: begin
        if (is_mem_load) begin
          rsp_d.target  = mem_tgt;
          rsp_d.address = idx_mem;
        end else if (req_i.opcode == OP_PLAIN_LOAD) begin
          rsp_d.target  = TGT_REGFILE;
          rsp_d.address = {8'h00, idx_sum};
          rsp_d.illegal = in_set1_upper(idx_sum);
        end else begin
          rsp_d.illegal = 1'b1;
        end
      end
      MODE_DIRECT: begin
        if ((req_i.opcode == OP_ABSOLUTE_JUMP) || (req_i.opcode == OP_CALL)) begin
          rsp_d.target  = TGT_PC;
          rsp_d.address = req_i.operand;
        end else if (is_mem_load) begin
          rsp_d.target  = mem_tgt;
          rsp_d.address = req_i.operand;
        end else begin
          rsp_d.illegal = 1'b1;
        end
      end
      MODE_INDIRECT_VECTOR: begin
        if (req_i.opcode == OP_CALL) begin
          rsp_d.target  = TGT_PC;
          rsp_d.address = vec_rdata_i;
        end else begin
          rsp_d.illegal = 1'b1;
        end
      end
      MODE_PC_RELATIVE: begin
        if (is_branch) begin
          rsp_d.target  = TGT_PC;
          rsp_d.address = rel_target;
        end else begin
          rsp_d.illegal = 1'b1;
        end
      end
      MODE_IMMEDIATE: begin
        rsp_d.target = TGT_VALUE;
        rsp_d.value  = req_i.wide_immediate ? req_i.operand
                                            : {8'h00, req_i.operand[7:0]};
      end
      default: begin
        rsp_d.illegal = 1'b1;
      end
    endcase
  end

  // Pointers are written by the core through the register-file address map.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      working_pointer_zero_q <= WORKING_POINTER_ZERO_RST;
      working_pointer_one_q  <= WORKING_POINTER_ONE_RST;
    end else if (reg_wr_i) begin
      if (reg_wr_addr_i == WORKING_POINTER_ZERO_ADDR) begin
        working_pointer_zero_q <= reg_wr_data_i;
      end
      if (reg_wr_addr_i == WORKING_POINTER_ONE_ADDR) begin
        working_pointer_one_q <= reg_wr_data_i;
      end
    end
  end

  // The result is registered so downstream memories see a stable address for a full cycle.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rsp_q       <= '0;
      rsp_valid_q <= 1'b0;
    end else begin
      rsp_valid_q <= req_valid_i;
      if (req_valid_i) begin
        rsp_q <= rsp_d;
      end
    end
  end

  assign rsp_o                  = rsp_q;
  assign rsp_valid_o            = rsp_valid_q;
  assign working_pointer_zero_o = working_pointer_zero_q;
  assign working_pointer_one_o  = working_pointer_one_q;

  property p_working_select;
    @(posedge clk_i) disable iff (rst_i)
      (req_valid_i && req_i.mode == MODE_REGISTER && req_i.reg_field[7:4] == 4'hC)
        |-> rf_addr_o[2:0] == req_i.reg_field[2:0] &&
            rf_addr_o[7:3] == (req_i.reg_field[3] ? working_pointer_one_q[7:3]
                                                  : working_pointer_zero_q[7:3]);
  endproperty
  a_working_select: assert property (p_working_select) else $error("bad working address");

  property p_register_value;
    @(posedge clk_i) disable iff (rst_i)
      (req_valid_i && req_i.mode == MODE_REGISTER && !req_i.pair)
        |=> rsp_valid_o && rsp_o.value == {8'h00, $past(rf_rdata_i)};
  endproperty
  a_register_value: assert property (p_register_value) else $error("register value wrong");

  property p_ir_protect;
    @(posedge clk_i) disable iff (rst_i)
      (req_valid_i && req_i.mode == MODE_INDIRECT_REGISTER && !req_i.use_memory_space &&
       rf_rdata_i >= 8'hC0) |=> rsp_o.illegal;
  endproperty
  a_ir_protect: assert property (p_ir_protect) else $error("indirect reached set 1");

  property p_idx_protect;
    @(posedge clk_i) disable iff (rst_i)
      (rsp_valid_o && rsp_o.target == TGT_REGFILE && !rsp_o.illegal)
        |-> rsp_o.address < 16'h00C0;
  endproperty
  a_idx_protect: assert property (p_idx_protect) else $error("register target in set 1");

  property p_vector_call_only;
    @(posedge clk_i) disable iff (rst_i)
      (req_valid_i && req_i.mode == MODE_INDIRECT_VECTOR && req_i.opcode != OP_CALL)
        |=> rsp_o.illegal && rsp_o.target == TGT_NONE;
  endproperty
  a_vector_call_only: assert property (p_vector_call_only) else $error("vector off call");

  property p_relative;
    @(posedge clk_i) disable iff (rst_i)
      (req_valid_i && req_i.mode == MODE_PC_RELATIVE && req_i.opcode == OP_RELATIVE_JUMP)
        |=> rsp_o.address == 16'($past(pc_next_i) + {{8{$past(req_i.operand[7])}},
                                                       $past(req_i.operand[7:0])});
  endproperty
  a_relative: assert property (p_relative) else $error("relative target wrong");

  property p_direct_jump;
    @(posedge clk_i) disable iff (rst_i)
      (req_valid_i && req_i.mode == MODE_DIRECT && req_i.opcode == OP_ABSOLUTE_JUMP)
        |=> rsp_o.target == TGT_PC && rsp_o.address == $past(req_i.operand);
  endproperty
  a_direct_jump: assert property (p_direct_jump) else $error("direct jump wrong");

  property p_vector_page;
    @(posedge clk_i) disable iff (rst_i) vec_addr_o[15:8] == 8'h00;
  endproperty
  a_vector_page: assert property (p_vector_page) else $error("vector outside page");

  property p_immediate_byte;
    @(posedge clk_i) disable iff (rst_i)
      (req_valid_i && req_i.mode == MODE_IMMEDIATE && !req_i.wide_immediate)
        |=> rsp_o.value[15:8] == 8'h00 && rsp_o.value[7:0] == $past(req_i.operand[7:0]);
  endproperty
  a_immediate_byte: assert property (p_immediate_byte) else $error("immediate wrong");

  property p_pair_value;
    @(posedge clk_i) disable iff (rst_i)
      (req_valid_i && req_i.mode == MODE_REGISTER && req_i.pair)
        |=> rsp_o.value == {$past(rf_rdata_hi_i), $past(rf_rdata_i)};
  endproperty
  a_pair_value: assert property (p_pair_value) else $error("pair value wrong");

  property p_plain_reg;
    @(posedge clk_i) disable iff (rst_i)
      (req_valid_i && req_i.mode == MODE_REGISTER &&
       req_i.reg_field[7:4] != WORKING_NIBBLE_PREFIX) |-> rf_addr_o == req_i.reg_field;
  endproperty
  a_plain_reg: assert property (p_plain_reg) else $error("plain register moved");

  property p_ir_memory;
    @(posedge clk_i) disable iff (rst_i)
      (req_valid_i && req_i.mode == MODE_INDIRECT_REGISTER && req_i.use_memory_space)
        |=> rsp_o.address == {$past(rf_rdata_hi_i), $past(rf_rdata_i)};
  endproperty
  a_ir_memory: assert property (p_ir_memory) else $error("pair pointer wrong");

  property p_idx_sum;
    @(posedge clk_i) disable iff (rst_i)
      (req_valid_i && req_i.mode == MODE_INDEXED && req_i.opcode == OP_PLAIN_LOAD)
        |=> rsp_o.address[7:0] == 8'($past(req_i.operand[7:0]) + $past(rf_rdata_i));
  endproperty
  a_idx_sum: assert property (p_idx_sum) else $error("indexed sum wrong");

  property p_regfile_byte;
    @(posedge clk_i) disable iff (rst_i)
      (rsp_valid_o && rsp_o.target == TGT_REGFILE) |-> rsp_o.address[15:8] == 8'h00;
  endproperty
  a_regfile_byte: assert property (p_regfile_byte) else $error("register address wide");

  property p_idx_short;
    @(posedge clk_i) disable iff (rst_i)
      (req_valid_i && req_i.mode == MODE_INDEXED && req_i.short_offset &&
       req_i.opcode == OP_EXTERNAL_DATA_LOAD)
        |=> rsp_o.address == 16'({$past(rf_rdata_hi_i), $past(rf_rdata_i)} +
                                 {{8{$past(req_i.operand[7])}}, $past(req_i.operand[7:0])});
  endproperty
  a_idx_short: assert property (p_idx_short) else $error("short offset wrong");

  property p_idx_long;
    @(posedge clk_i) disable iff (rst_i)
      (req_valid_i && req_i.mode == MODE_INDEXED && !req_i.short_offset &&
       req_i.opcode == OP_PROGRAM_MEMORY_LOAD)
        |=> rsp_o.target == TGT_PROGRAM &&
            rsp_o.address == 16'({$past(rf_rdata_hi_i), $past(rf_rdata_i)} +
                                 $past(req_i.operand));
  endproperty
  a_idx_long: assert property (p_idx_long) else $error("indexed memory wrong");

  property p_idx_plain_only;
    @(posedge clk_i) disable iff (rst_i)
      (req_valid_i && req_i.mode == MODE_INDEXED &&
       !(req_i.opcode inside {OP_PLAIN_LOAD, OP_PROGRAM_MEMORY_LOAD, OP_EXTERNAL_DATA_LOAD}))
        |=> rsp_o.illegal;
  endproperty
  a_idx_plain_only: assert property (p_idx_plain_only) else $error("indexed on wrong op");

  property p_direct_load;
    @(posedge clk_i) disable iff (rst_i)
      (req_valid_i && req_i.mode == MODE_DIRECT && req_i.opcode == OP_EXTERNAL_DATA_LOAD)
        |=> rsp_o.target == TGT_EXTERNAL && rsp_o.address == $past(req_i.operand);
  endproperty
  a_direct_load: assert property (p_direct_load) else $error("direct load wrong");

  property p_vector_call;
    @(posedge clk_i) disable iff (rst_i)
      (req_valid_i && req_i.mode == MODE_INDIRECT_VECTOR && req_i.opcode == OP_CALL)
        |=> rsp_o.target == TGT_PC && rsp_o.address == $past(vec_rdata_i);
  endproperty
  a_vector_call: assert property (p_vector_call) else $error("vector target wrong");

  property p_relative_ops;
    @(posedge clk_i) disable iff (rst_i)
      (req_valid_i && req_i.mode == MODE_PC_RELATIVE)
        |=> rsp_o.illegal == !($past(req_i.opcode) inside {OP_BIT_TEST_BRANCH_FALSE,
            OP_BIT_TEST_BRANCH_TRUE, OP_DECREMENT_BRANCH_NONZERO, OP_COMPARE_INC_BRANCH_EQUAL,
            OP_COMPARE_INC_BRANCH_UNEQUAL, OP_RELATIVE_JUMP});
  endproperty
  a_relative_ops: assert property (p_relative_ops) else $error("relative decode wrong");

  property p_immediate_word;
    @(posedge clk_i) disable iff (rst_i)
      (req_valid_i && req_i.mode == MODE_IMMEDIATE && req_i.wide_immediate)
        |=> rsp_o.target == TGT_VALUE && rsp_o.value == $past(req_i.operand);
  endproperty
  a_immediate_word: assert property (p_immediate_word) else $error("immediate word wrong");

  property p_pointer_write;
    @(posedge clk_i) disable iff (rst_i)
      (reg_wr_i && reg_wr_addr_i == WORKING_POINTER_ONE_ADDR)
        |=> working_pointer_one_o == $past(reg_wr_data_i);
  endproperty
  a_pointer_write: assert property (p_pointer_write) else $error("pointer write lost");

endmodule

// >>> include/oag_pkg.sv
package oag_pkg;

  localparam logic [7:0] WORKING_POINTER_ZERO_ADDR = 8'hD6;
  localparam logic [7:0] WORKING_POINTER_ONE_ADDR  = 8'hD7;
  localparam logic [7:0] WORKING_POINTER_ZERO_RST  = 8'hC0;
  localparam logic [7:0] WORKING_POINTER_ONE_RST   = 8'hC8;
  localparam logic [3:0] WORKING_NIBBLE_PREFIX     = 4'hC;
  localparam logic [7:0] SET1_PROTECT_BASE         = 8'hC0;
  localparam int         SLICE_LOW_BITS            = 3;
  localparam int         POINTER_SEL_BIT           = 3;

  typedef enum logic [2:0] {
    MODE_REGISTER          = 3'b000,
    MODE_INDIRECT_REGISTER = 3'b001,
    MODE_INDEXED           = 3'b010,
    MODE_DIRECT            = 3'b011,
    MODE_INDIRECT_VECTOR   = 3'b100,
    MODE_PC_RELATIVE       = 3'b101,
    MODE_IMMEDIATE         = 3'b110
  } addr_mode_e;

  typedef enum logic [3:0] {
    OP_PLAIN_LOAD                 = 4'h0,
    OP_PROGRAM_MEMORY_LOAD        = 4'h1,
    OP_EXTERNAL_DATA_LOAD         = 4'h2,
    OP_ABSOLUTE_JUMP              = 4'h3,
    OP_CALL                       = 4'h4,
    OP_BIT_TEST_BRANCH_FALSE      = 4'h5,
    OP_BIT_TEST_BRANCH_TRUE       = 4'h6,
    OP_DECREMENT_BRANCH_NONZERO   = 4'h7,
    OP_COMPARE_INC_BRANCH_EQUAL   = 4'h8,
    OP_COMPARE_INC_BRANCH_UNEQUAL = 4'h9,
    OP_RELATIVE_JUMP              = 4'hA,
    OP_ALU                        = 4'hB
  } opcode_e;

  typedef enum logic [2:0] {
    TGT_NONE     = 3'b000,
    TGT_REGFILE  = 3'b001,
    TGT_PROGRAM  = 3'b010,
    TGT_EXTERNAL = 3'b011,
    TGT_PC       = 3'b100,
    TGT_VALUE    = 3'b101
  } target_e;

  typedef struct packed {
    opcode_e    opcode;
    addr_mode_e mode;
    logic       pair;
    logic       use_memory_space;
    logic       short_offset;
    logic       wide_immediate;
    logic [7:0] reg_field;
    logic [15:0] operand;
  } decode_req_s;

  typedef struct packed {
    target_e     target;
    logic [15:0] address;
    logic [15:0] value;
    logic        illegal;
  } decode_rsp_s;

endpackage

// >>> verif/mem_model.sv
`timescale 1ns/1ps
module mem_model (
  input  wire logic [7:0]  rf_addr_i,
  input  wire logic [15:0] vec_addr_i,
  output logic      [7:0]  rf_rdata_o,
  output logic      [7:0]  rf_rdata_hi_o,
  output logic      [15:0] vec_rdata_o
);
  // Contents are a fixed scramble of the address, so every location differs without storage.
  function automatic logic [7:0] rf_byte(input logic [7:0] a);
    return {a[2:0], a[7:3]} ^ 8'h5A;
  endfunction
  function automatic logic [15:0] vec_word(input logic [7:0] a);
    return {rf_byte(a), ~a};
  endfunction
  assign rf_rdata_o    = rf_byte(rf_addr_i);
  assign rf_rdata_hi_o = rf_byte(rf_addr_i + 8'h01);
  // Upper address bits are ignored here; the bench checks them at the port.
  assign vec_rdata_o   = vec_word(vec_addr_i[7:0]);
endmodule

// >>> verif/tb_top.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin errors++; \
  $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module tb_top;
  import oag_pkg::*;
  typedef struct packed {
    decode_rsp_s rsp;
    logic        by_value;
  } note_s;
  logic        clk_i         = 1'b0;
  logic        rst_i         = 1'b1;
  logic        req_valid_i   = 1'b0;
  decode_req_s req_i         = '0;
  logic [15:0] pc_next_i     = 16'h0000;
  logic        reg_wr_i      = 1'b0;
  logic [7:0]  reg_wr_addr_i = 8'h00;
  logic [7:0]  reg_wr_data_i = 8'h00;
  logic [7:0]  rf_addr_o, rf_rdata_i, rf_rdata_hi_i, ptr0_o, ptr1_o, wp0, wp1, f, x, g, s;
  logic [15:0] vec_addr_o, vec_rdata_i, d, e, bp;
  logic        rsp_valid_o;
  decode_rsp_s rsp_o;
  note_s       notes[$];
  note_s       got;
  int          errors     = 0;
  int          n_compared = 0;
  opcode_e     rel_ops[6] = '{OP_BIT_TEST_BRANCH_FALSE, OP_BIT_TEST_BRANCH_TRUE,
    OP_DECREMENT_BRANCH_NONZERO, OP_COMPARE_INC_BRANCH_EQUAL,
    OP_COMPARE_INC_BRANCH_UNEQUAL, OP_RELATIVE_JUMP};
  always #5 clk_i = ~clk_i;
  operand_address_generator uut (.clk_i(clk_i), .rst_i(rst_i), .req_valid_i(req_valid_i),
    .req_i(req_i), .pc_next_i(pc_next_i), .reg_wr_i(reg_wr_i), .reg_wr_addr_i(reg_wr_addr_i),
    .reg_wr_data_i(reg_wr_data_i), .rf_addr_o(rf_addr_o), .rf_rdata_i(rf_rdata_i),
    .rf_rdata_hi_i(rf_rdata_hi_i), .vec_addr_o(vec_addr_o), .vec_rdata_i(vec_rdata_i),
    .rsp_valid_o(rsp_valid_o), .rsp_o(rsp_o), .working_pointer_zero_o(ptr0_o),
    .working_pointer_one_o(ptr1_o));
  mem_model mem (.rf_addr_i(rf_addr_o), .vec_addr_i(vec_addr_o), .rf_rdata_o(rf_rdata_i),
    .rf_rdata_hi_o(rf_rdata_hi_i), .vec_rdata_o(vec_rdata_i));
  function automatic logic [7:0] resolve(input logic [7:0] r);
    logic [7:0] p;
    p = r[3] ? wp1 : wp0;
    return (r[7:4] == WORKING_NIBBLE_PREFIX) ? {p[7:3], r[2:0]} : r;
  endfunction
  function automatic logic [7:0] rb(input logic [7:0] a);
    return mem.rf_byte(a);
  endfunction
  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge clk_i);
    reg_wr_i = 1'b1;
    reg_wr_addr_i = a;
    reg_wr_data_i = v;
    if (a == WORKING_POINTER_ZERO_ADDR) wp0 = v;
    if (a == WORKING_POINTER_ONE_ADDR) wp1 = v;
    @(negedge clk_i);
    reg_wr_i = 1'b0;
    `CHK("ptr0", wp0, ptr0_o)
    `CHK("ptr1", wp1, ptr1_o)
  endtask
  task automatic go(input opcode_e o, input addr_mode_e m, input logic [3:0] fl,
                    input logic [7:0] fld, input target_e t, input logic [15:0] v,
                    input logic bv, input logic ill);
    note_s n;
    @(negedge clk_i);
    req_valid_i = 1'b1;
    req_i = '{o, m, fl[3], fl[2], fl[1], fl[0], fld, d};
    #1;
    `CHK("rf_addr", resolve(fld), rf_addr_o)
    `CHK("vec_addr", {8'h00, d[7:0]}, vec_addr_o)
    n.rsp = '{t, bv ? 16'h0000 : v, bv ? v : 16'h0000, ill};
    n.by_value = bv;
    notes.push_back(n);
  endtask
  // Responses are matched in order; an extra one with no note pending fails at once, a dropped one leaves a note for the final check.
  always @(negedge clk_i) begin
    if (rsp_valid_o === 1'b1) begin
      if (notes.size() == 0) `CHK("extra response", 1'b0, 1'b1)
      else begin
        got = notes.pop_front();
        `CHK("illegal", got.rsp.illegal, rsp_o.illegal)
        if (got.rsp.illegal !== 1'b1 && got.rsp.target !== TGT_NONE)
          `CHK("target", got.rsp.target, rsp_o.target)
        if (got.rsp.illegal !== 1'b1 && got.by_value)
          `CHK("value", got.rsp.value, rsp_o.value)
        if (got.rsp.illegal !== 1'b1 && !got.by_value)
          `CHK("address", got.rsp.address, rsp_o.address)
      end
    end
  end
  initial begin
    #50000;
    errors++;
    $display("[FAIL] watchdog expected done seen hang");
    final_report();
  end
  initial begin
    void'($urandom(38));
    repeat (10) @(posedge clk_i);
    @(negedge clk_i);
    rst_i = 1'b0;
    wp0 = WORKING_POINTER_ZERO_RST;
    wp1 = WORKING_POINTER_ONE_RST;
    `CHK("ptr0 reset", WORKING_POINTER_ZERO_RST, ptr0_o)
    `CHK("ptr1 reset", WORKING_POINTER_ONE_RST, ptr1_o)
    for (int r = 0; r < 12; r++) begin
      wr(WORKING_POINTER_ZERO_ADDR, 8'($urandom()));
      wr(WORKING_POINTER_ONE_ADDR, 8'($urandom()));
      wr(8'hD5, 8'($urandom()));
      f = 8'($urandom());
      x = {WORKING_NIBBLE_PREFIX, 4'($urandom())};
      d = 16'($urandom());
      pc_next_i = 16'($urandom());
      e = {{8{d[7]}}, d[7:0]};
      g = rb(resolve(f));
      bp = {rb(resolve(x) + 8'h01), rb(resolve(x))};
      s = d[7:0] + rb(resolve(x));
      go(OP_ALU, MODE_REGISTER, 4'h0, f, TGT_VALUE, {8'h00, g}, 1'b1, 1'b0);
      go(OP_ALU, MODE_REGISTER, 4'h8, x, TGT_VALUE, bp, 1'b1, 1'b0);
      go(OP_PLAIN_LOAD, MODE_INDIRECT_REGISTER, 4'h0, f, TGT_REGFILE, {8'h00, g}, 1'b0,
         g >= SET1_PROTECT_BASE);
      go(OP_EXTERNAL_DATA_LOAD, MODE_INDIRECT_REGISTER, 4'hC, x, TGT_EXTERNAL, bp, 1'b0,
         1'b0);
      go(OP_ABSOLUTE_JUMP, MODE_INDIRECT_REGISTER, 4'hC, x, TGT_PROGRAM, bp, 1'b0, 1'b0);
      go(OP_PLAIN_LOAD, MODE_INDEXED, 4'h0, x, TGT_REGFILE, {8'h00, s}, 1'b0,
         s >= SET1_PROTECT_BASE);
      go(OP_PROGRAM_MEMORY_LOAD, MODE_INDEXED, 4'hC, x, TGT_PROGRAM, bp + d, 1'b0, 1'b0);
      go(OP_EXTERNAL_DATA_LOAD, MODE_INDEXED, 4'hE, x, TGT_EXTERNAL, bp + e, 1'b0, 1'b0);
      go(OP_ALU, MODE_INDEXED, 4'h0, x, TGT_NONE, 16'h0000, 1'b0, 1'b1);
      go(OP_ABSOLUTE_JUMP, MODE_DIRECT, 4'h0, f, TGT_PC, d, 1'b0, 1'b0);
      go(OP_CALL, MODE_DIRECT, 4'h0, f, TGT_PC, d, 1'b0, 1'b0);
      go(OP_PROGRAM_MEMORY_LOAD, MODE_DIRECT, 4'h4, f, TGT_PROGRAM, d, 1'b0, 1'b0);
      go(OP_EXTERNAL_DATA_LOAD, MODE_DIRECT, 4'h4, f, TGT_EXTERNAL, d, 1'b0, 1'b0);
      go(OP_ALU, MODE_DIRECT, 4'h0, f, TGT_NONE, 16'h0000, 1'b0, 1'b1);
      go(OP_CALL, MODE_INDIRECT_VECTOR, 4'h0, f, TGT_PC, mem.vec_word(d[7:0]), 1'b0,
         1'b0);
      go(OP_ABSOLUTE_JUMP, MODE_INDIRECT_VECTOR, 4'h0, f, TGT_NONE, 16'h0000, 1'b0, 1'b1);
      for (int k = 0; k < 6; k++) begin
        go(rel_ops[k], MODE_PC_RELATIVE, 4'h0, f, TGT_PC, pc_next_i + e, 1'b0, 1'b0);
      end
      go(OP_ALU, MODE_PC_RELATIVE, 4'h0, f, TGT_NONE, 16'h0000, 1'b0, 1'b1);
      go(OP_ALU, MODE_IMMEDIATE, 4'h1, f, TGT_VALUE, d, 1'b1, 1'b0);
      go(OP_PLAIN_LOAD, MODE_IMMEDIATE, 4'h0, f, TGT_VALUE, {8'h00, d[7:0]}, 1'b1, 1'b0);
      @(negedge clk_i);
      req_valid_i = 1'b0;
    end
    repeat (3) @(negedge clk_i);
    `CHK("pending notes", 0, notes.size())
    rst_i = 1'b1;
    repeat (2) @(negedge clk_i);
    `CHK("valid in reset", 1'b0, rsp_valid_o)
    `CHK("ptr0 reset", WORKING_POINTER_ZERO_RST, ptr0_o)
    `CHK("ptr1 reset", WORKING_POINTER_ONE_RST, ptr1_o)
    final_report();
  end
endmodule
